// ---- enc_out_pkg.sv ----
package enc_out_pkg;
    // Bus word offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_RES       = 8'h04;
    localparam logic [7:0] OFS_PITCH     = 8'h08;
    localparam logic [7:0] OFS_MAXSPD    = 8'h0c;
    localparam logic [7:0] OFS_OFFDLY    = 8'h10;
    localparam logic [7:0] OFS_RUNWAIT   = 8'h14;
    localparam logic [7:0] OFS_BRKSPD    = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1c;
    localparam logic [7:0] OFS_PITCH_LO  = 8'h20;
    localparam logic [7:0] OFS_PITCH_HI  = 8'h24;
    localparam logic [7:0] OFS_DIVS      = 8'h28;
    // Control register fields
    localparam int CTRL_ORIGIN_BIT  = 0;
    localparam int CTRL_SERIAL_BIT  = 1;
    localparam int CTRL_REVERSE_BIT = 2;
    localparam int CTRL_AUTO_BIT    = 3;
    localparam int CTRL_RESTART_BIT = 8;
    // Status register fields
    localparam int ST_SETERR_BIT = 0;
    localparam int ST_OVSPD_BIT  = 1;
    localparam int ST_BRAKE_BIT  = 2;
    localparam int ST_POWER_BIT  = 3;
    // Values after reset
    localparam logic [12:0] RES_RST     = 13'h0014;
    localparam logic [31:0] PITCH_RST   = 32'h0000_07d0;
    localparam logic [15:0] MAXSPD_RST  = 16'h0032;
    localparam logic [7:0]  OFFDLY_RST  = 8'h00;
    localparam logic [7:0]  RUNWAIT_RST = 8'h32;
    localparam logic [15:0] BRKSPD_RST  = 16'h000a;
    localparam logic [15:0] DIVS_RST    = 16'h0100;
    // Range and upper-limit figures
    localparam logic [12:0] RES_MIN     = 13'h0001;
    localparam logic [12:0] RES_MAX     = 13'h1000;
    localparam logic [7:0]  LIMIT_DIV   = 8'h64;
    localparam logic [7:0]  LIMIT_MUL   = 8'h48;
    // Timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int BRAKE_UNIT_NS  = 10_000_000;
    localparam int TICK_CYCLES    = BRAKE_UNIT_NS / CLK_PERIOD_NS;
    localparam int NUM_ZERO       = 4;
    typedef enum logic [0:0] {ORIGIN_FWD_ONLY, ORIGIN_BOTH} origin_mode_e;
endpackage : enc_out_pkg

// ---- enc_pulse_out.sv ----
// Notes on behaviour
// - Direction-sensitive scales may give origin pulses at two positions.
// - Origin gating follows the scale count direction, not the reverse setting.
// - First forward crossing emits a pulse; later crossings emit in both directions.
// - Reverse-first crossing emits nothing until a forward crossing has emitted.
// - Each zero point of a multi-zero scale is gated on its own.
// - Origin mode 0 forward only, 1 both ways; applied at restart.
// - With a serial converter unit, origin pulses pass both directions.
// - Resolution 1 to 4096 edges per pitch, default 20, applied at restart.
// - Feedback counts per pitch are divided down to the resolution in edges.
// - Upper limit is pitch over 100, over max speed, times 72.
// - Out-of-range or over-limit resolution raises the setting error alarm.
// - Speed above the resolution's limit raises the output overspeed alarm.
// - With auto pitch, manual pitch is ignored; recognised pitch is monitored.
// - Servo-off brake timing uses off delay, running wait and speed level.
// - Phases A and B are output 90 degrees apart.
// - Origin pulse is one phase A pulse wide.
// - Reverse direction mode keeps the same output phase form.
`timescale 1ns/1ps
`default_nettype none
module enc_pulse_out #(
    parameter int TICK_CYCLES = enc_out_pkg::TICK_CYCLES  // Cycles per 10 ms unit
) (
    input  wire logic        clk,          // 40 MHz clock
    input  wire logic        nrst,         // Sync reset, active low
    input  wire logic        hsel,         // AHB select
    input  wire logic [31:0] haddr,        // AHB address
    input  wire logic [1:0]  htrans,       // AHB transfer type
    input  wire logic        hwrite,       // AHB write
    input  wire logic [2:0]  hsize,        // AHB size
    input  wire logic [31:0] hwdata,       // AHB write data
    input  wire logic        hready,       // AHB bus ready
    output logic             hreadyout,    // AHB slave ready
    output logic [31:0]      hrdata,       // AHB read data
    output logic             hresp,        // AHB response
    input  wire logic        fb_step,      // One feedback count
    input  wire logic        fb_dir,       // Scale counts up
    input  wire logic        zero_hit,     // Zero point crossed
    input  wire logic [1:0]  zero_id,      // Which zero point
    input  wire logic [31:0] auto_pitch,   // Recognised pitch
    input  wire logic [15:0] motor_speed,  // Speed magnitude
    input  wire logic        servo_on,     // Servo ON command
    output logic             quad_out_a,   // Phase A
    output logic             quad_out_b,   // Phase B
    output logic             origin_out,   // Phase C
    output logic             brake_release_out, // High releases brake
    output logic             motor_power,  // Motor power on
    output logic             alarm_out     // Any alarm
);
    localparam int NZ = enc_out_pkg::NUM_ZERO;
    typedef enum logic [1:0] {BR_OFF, BR_ON, BR_STOP_DLY, BR_RUN_WAIT} brake_e;

    quad_if q ();

    logic        ph_wr_q;
    logic [7:0]  ph_addr_q;
    logic [3:0]  ctrl_q;
    logic        restart_q;
    logic [12:0] res_cfg_q;
    logic [31:0] pitch_cfg_q;
    logic [15:0] maxspd_q;
    logic [7:0]  offdly_q;
    logic [7:0]  runwait_q;
    logic [15:0] brkspd_q;
    logic [15:0] divs_q;
    logic [12:0] res_act_q;
    logic        mode_act_q;
    logic        serial_act_q;
    logic        seterr_q;
    logic        ovspd_q;
    logic [31:0] pitch_eff;
    logic [39:0] lim_lhs;
    logic [39:0] lim_rhs;
    logic [39:0] spd_lhs;
    logic [31:0] acc_q;
    logic [31:0] acc_sum;
    logic        step_q;
    logic        dir_q;
    logic [NZ-1:0] hit_vec;
    logic [NZ-1:0] emit_vec;
    logic        both_dirs;
    logic        pend_q;
    logic        a_prev_q;
    brake_e      br_q;
    logic [31:0] tick_q;
    logic        tick;
    logic [7:0]  units_q;
    logic        wr_en;
    logic        clr_ovspd;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave

    // Zero-wait slave: capture address phase, act in the data phase
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ph_wr_q   <= 1'b0;
            ph_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (hready) begin
            ph_wr_q   <= hsel && htrans[1] && hwrite;
            ph_addr_q <= haddr[7:0];
        end
    end

    assign wr_en     = ph_wr_q;
    assign clr_ovspd = wr_en && ph_addr_q == enc_out_pkg::OFS_STATUS
                       && hwdata[enc_out_pkg::ST_OVSPD_BIT];

    // Configuration writes; restart bit is a one-cycle self-clearing strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_q      <= 4'h0;
            restart_q   <= 1'b0;
            res_cfg_q   <= enc_out_pkg::RES_RST;
            pitch_cfg_q <= enc_out_pkg::PITCH_RST;
            maxspd_q    <= enc_out_pkg::MAXSPD_RST;
            offdly_q    <= enc_out_pkg::OFFDLY_RST;
            runwait_q   <= enc_out_pkg::RUNWAIT_RST;
            brkspd_q    <= enc_out_pkg::BRKSPD_RST;
            divs_q      <= enc_out_pkg::DIVS_RST;
        end else begin
            restart_q <= 1'b0;
            if (wr_en) begin
                unique case (ph_addr_q)
                    enc_out_pkg::OFS_CTRL: begin
                        ctrl_q    <= hwdata[3:0];
                        restart_q <= hwdata[enc_out_pkg::CTRL_RESTART_BIT];
                    end
                    enc_out_pkg::OFS_RES:     res_cfg_q   <= hwdata[12:0];
                    enc_out_pkg::OFS_PITCH:   pitch_cfg_q <= hwdata;
                    enc_out_pkg::OFS_MAXSPD:  maxspd_q    <= hwdata[15:0];
                    enc_out_pkg::OFS_OFFDLY:  offdly_q    <= hwdata[7:0];
                    enc_out_pkg::OFS_RUNWAIT: runwait_q   <= hwdata[7:0];
                    enc_out_pkg::OFS_BRKSPD:  brkspd_q    <= hwdata[15:0];
                    enc_out_pkg::OFS_DIVS:    divs_q      <= hwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Read data registered in the address phase, unmapped reads as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                enc_out_pkg::OFS_CTRL:     hrdata <= {28'h0, ctrl_q};
                enc_out_pkg::OFS_RES:      hrdata <= {19'h0, res_cfg_q};
                enc_out_pkg::OFS_PITCH:    hrdata <= pitch_cfg_q;
                enc_out_pkg::OFS_MAXSPD:   hrdata <= {16'h0, maxspd_q};
                enc_out_pkg::OFS_OFFDLY:   hrdata <= {24'h0, offdly_q};
                enc_out_pkg::OFS_RUNWAIT:  hrdata <= {24'h0, runwait_q};
                enc_out_pkg::OFS_BRKSPD:   hrdata <= {16'h0, brkspd_q};
                enc_out_pkg::OFS_STATUS:   hrdata <= {28'h0, motor_power,
                                              brake_release_out, ovspd_q, seterr_q};
                enc_out_pkg::OFS_PITCH_LO: hrdata <= {16'h0, pitch_eff[15:0]};
                enc_out_pkg::OFS_PITCH_HI: hrdata <= {16'h0, pitch_eff[31:16]};
                enc_out_pkg::OFS_DIVS:     hrdata <= {16'h0, divs_q};
                default:                   hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active settings and alarms

    // Mode and resolution only change at restart, so output stays coherent
    always_ff @(posedge clk) begin
        if (!nrst) begin
            res_act_q    <= enc_out_pkg::RES_RST;
            mode_act_q   <= enc_out_pkg::ORIGIN_FWD_ONLY;
            serial_act_q <= 1'b0;
        end else if (restart_q) begin
            res_act_q    <= res_cfg_q;
            mode_act_q   <= ctrl_q[enc_out_pkg::CTRL_ORIGIN_BIT];
            serial_act_q <= ctrl_q[enc_out_pkg::CTRL_SERIAL_BIT];
        end
    end

    // Auto-recognised pitch overrides the manual one
    assign pitch_eff = ctrl_q[enc_out_pkg::CTRL_AUTO_BIT] ? auto_pitch : pitch_cfg_q;

    // res*maxspd*100 <= pitch*72 is the upper limit without a divider
    assign lim_lhs = 40'(res_act_q) * 40'(maxspd_q) * 40'(enc_out_pkg::LIMIT_DIV);
    assign lim_rhs = 40'(pitch_eff) * 40'(enc_out_pkg::LIMIT_MUL);
    assign spd_lhs = 40'(res_act_q) * 40'(motor_speed) * 40'(enc_out_pkg::LIMIT_DIV);

    // Setting error is a live level; overspeed is sticky, cleared by write 1
    always_ff @(posedge clk) begin
        if (!nrst) begin
            seterr_q <= 1'b0;
            ovspd_q  <= 1'b0;
        end else begin
            seterr_q <= res_act_q < enc_out_pkg::RES_MIN
                        || res_act_q > enc_out_pkg::RES_MAX
                        || lim_lhs > lim_rhs;
            if (spd_lhs > lim_rhs) begin
                ovspd_q <= 1'b1;
            end else if (clr_ovspd) begin
                ovspd_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            alarm_out <= 1'b0;
        end else begin
            alarm_out <= seterr_q || ovspd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divider: add resolution per count, step when a pitch's worth passes

    // At most one output edge per feedback count; resolution above the
    // count per pitch is clipped rather than bursting
    assign acc_sum = acc_q + 32'(res_act_q);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            acc_q  <= 32'h0000_0000;
            step_q <= 1'b0;
            dir_q  <= 1'b0;
        end else begin
            step_q <= 1'b0;
            if (fb_step && !seterr_q) begin
                dir_q <= fb_dir;
                if (acc_sum >= 32'(divs_q)) begin
                    acc_q  <= acc_sum - 32'(divs_q);
                    step_q <= 1'b1;
                end else begin
                    acc_q <= acc_sum;
                end
            end
        end
    end

    assign q.step = step_q;
    assign q.dir  = dir_q;

    quad_gen u_quad (
        .clk  (clk),
        .nrst (nrst),
        .q    (q.gen)
    );

    assign quad_out_a = q.phase_a;
    assign quad_out_b = q.phase_b;

    ////////////////////////////////////////////////////////////////////////
    // Origin gating, one gate per zero point

    // Raw scale direction decides; the reverse select is not consulted
    assign both_dirs = mode_act_q || serial_act_q;

    genvar gi;
    generate
        for (gi = 0; gi < NZ; gi++) begin : g_zero
            assign hit_vec[gi] = zero_hit && zero_id == 2'(gi);
            origin_gate u_gate (
                .clk       (clk),
                .nrst      (nrst),
                .hit       (hit_vec[gi]),
                .fwd       (fb_dir),
                .both_dirs (both_dirs),
                .emit      (emit_vec[gi])
            );
        end
    endgenerate

    // Origin waits for the next phase A rise and matches its width, one clock later
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend_q     <= 1'b0;
            a_prev_q   <= 1'b0;
            origin_out <= 1'b0;
        end else begin
            a_prev_q <= q.phase_a;
            if (|emit_vec) begin
                pend_q <= 1'b1;
            end else if (pend_q && q.phase_a && !a_prev_q) begin
                pend_q <= 1'b0;
            end
            if (pend_q && q.phase_a && !a_prev_q) begin
                origin_out <= 1'b1;
            end else if (!q.phase_a) begin
                origin_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Brake and motor power sequencing

    // 10 ms tick, only running while a timed state waits
    assign tick = tick_q == 32'(TICK_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tick_q <= 32'h0000_0000;
        end else if (br_q == BR_STOP_DLY || br_q == BR_RUN_WAIT) begin
            tick_q <= tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
        end else begin
            tick_q <= 32'h0000_0000;
        end
    end

    // Stopped: brake first, power after the delay. Moving or alarm:
    // power drops at once, brake waits for low speed or the wait time
    always_ff @(posedge clk) begin
        if (!nrst) begin
            br_q              <= BR_OFF;
            units_q           <= 8'h00;
            brake_release_out <= 1'b0;
            motor_power       <= 1'b0;
        end else begin
            unique case (br_q)
                BR_OFF: begin
                    if (servo_on && !alarm_out) begin
                        br_q              <= BR_ON;
                        brake_release_out <= 1'b1;
                        motor_power       <= 1'b1;
                    end
                end
                BR_ON: begin
                    units_q <= 8'h00;
                    if (alarm_out || (!servo_on && motor_speed >= brkspd_q)) begin
                        br_q        <= BR_RUN_WAIT;
                        motor_power <= 1'b0;
                    end else if (!servo_on) begin
                        br_q              <= BR_STOP_DLY;
                        brake_release_out <= 1'b0;
                    end
                end
                BR_STOP_DLY: begin
                    if (tick) begin
                        units_q <= units_q + 8'h01;
                    end
                    if (alarm_out || units_q >= offdly_q) begin
                        br_q        <= BR_OFF;
                        motor_power <= 1'b0;
                    end
                end
                BR_RUN_WAIT: begin
                    if (tick) begin
                        units_q <= units_q + 8'h01;
                    end
                    if (motor_speed < brkspd_q || units_q >= runwait_q) begin
                        br_q              <= BR_OFF;
                        brake_release_out <= 1'b0;
                    end
                end
            endcase
        end
    end
endmodule : enc_pulse_out
`default_nettype wire

// ---- enc_pulse_out_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module enc_pulse_out_assertions (
    input wire logic        clk,               // Clock
    input wire logic        nrst,              // Sync reset, low
    input wire logic        hreadyout,         // Slave ready
    input wire logic        hresp,             // Response
    input wire logic        fb_step,           // Feedback count
    input wire logic        servo_on,          // Servo ON
    input wire logic [15:0] motor_speed,       // Speed
    input wire logic        quad_out_a,        // Phase A
    input wire logic        quad_out_b,        // Phase B
    input wire logic        origin_out,        // Phase C
    input wire logic        brake_release_out, // Brake released
    input wire logic        motor_power,       // Power on
    input wire logic        alarm_out          // Any alarm
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    // Bus answers, quadrature form and origin pulse shape
    no_wait_a: assert property (hreadyout)
        else $error("wait state inserted");
    resp_okay_a: assert property (!hresp)
        else $error("error response");
    quad_gray_a: assert property (!($changed(quad_out_a) && $changed(quad_out_b)))
        else $error("both phases changed together");
    quad_cause_a: assert property ($changed({quad_out_a, quad_out_b}) |-> $past(fb_step, 2))
        else $error("phase edge without a feedback count");
    // Origin trails phase A by one clock
    origin_in_a_a: assert property (origin_out |-> $past(quad_out_a))
        else $error("origin outside phase A high");
    origin_rise_a: assert property ($rose(origin_out)
        |-> $past(quad_out_a) && !$past(quad_out_a, 2))
        else $error("origin not started with phase A");
    origin_hold_a: assert property (origin_out && quad_out_a |=> origin_out || !quad_out_a)
        else $error("origin shorter than phase A");
    // Brake sequencing checked with the default brake speed level
    power_on_a: assert property ($rose(servo_on) && !alarm_out |=> motor_power && brake_release_out)
        else $error("servo on did not power the motor");
    alarm_off_a: assert property ($rose(alarm_out) |-> ##[0:1] !motor_power)
        else $error("power kept on alarm");
    brake_stop_a: assert property ($fell(servo_on) && motor_speed < 16'h000a && !alarm_out
        |-> ##[0:1] !brake_release_out)
        else $error("brake not applied at stop");
    cover property ($rose(origin_out));
    cover property ($rose(alarm_out));
    cover property ($fell(motor_power));
endmodule : enc_pulse_out_assertions
bind enc_pulse_out enc_pulse_out_assertions u_chk (
    .clk, .nrst, .hreadyout, .hresp, .fb_step, .servo_on, .motor_speed, .quad_out_a,
    .quad_out_b, .origin_out, .brake_release_out, .motor_power, .alarm_out);
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int WAIT_CYC = 16  // Brake release plus settle, scaled down
) (
    input  wire logic clk,    // Clock
    input  wire logic qa,     // Phase A
    input  wire logic qb,     // Phase B
    input  wire logic qc,     // Origin
    input  wire logic son,    // Servo ON
    output int        pos,    // Signed edge count
    output int        org,    // Origin pulses seen
    output logic      ref_ok  // References may be sent
);
    logic [1:0] prv_q;
    logic       qc_q;
    int         wt_q;
    // Gray position of the phase pair, forward counts up
    function automatic logic [1:0] idx(input logic [1:0] ab);
        return {ab[1], ab[1] ^ ab[0]};
    endfunction : idx
    initial {pos, org, prv_q, qc_q, wt_q} = '0;
    // Count like a real host, illegal double steps are simply lost
    always @(posedge clk) begin
        case (2'(idx({qa, qb}) - idx(prv_q)))
            2'h1: pos <= pos + 1;
            2'h3: pos <= pos - 1;
            default: ;
        endcase
        prv_q <= {qa, qb};
        if (qc && !qc_q) org <= org + 1;
        qc_q <= qc;
        if (!son) wt_q <= 0;
        else if (wt_q < WAIT_CYC) wt_q <= wt_q + 1;
    end
    assign ref_ok = (wt_q >= WAIT_CYC);
endmodule : host_model
`default_nettype wire

// ---- origin_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module origin_gate (
    input  wire logic clk,        // System clock
    input  wire logic nrst,       // Sync reset, active low
    input  wire logic hit,        // Zero point crossed
    input  wire logic fwd,        // Scale counted up at crossing
    input  wire logic both_dirs,  // Pass reverse crossings too
    output logic      emit        // Origin request pulse
);
    logic seen_fwd_q;

    // Forward crossing arms reverse crossings until the next reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            seen_fwd_q <= 1'b0;
        end else if (hit && fwd) begin
            seen_fwd_q <= 1'b1;
        end
    end

    // Reverse crossing before any forward one is swallowed unless both_dirs is set
    always_ff @(posedge clk) begin
        if (!nrst) begin
            emit <= 1'b0;
        end else begin
            emit <= hit && (fwd || both_dirs || seen_fwd_q);
        end
    end
endmodule : origin_gate
`default_nettype wire

// ---- quad_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module quad_gen (
    input  wire logic clk,   // System clock
    input  wire logic nrst,  // Sync reset, active low
    quad_if.gen       q      // Step in, phases out
);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    // One output edge per step; gray walk keeps A and B 90 degrees apart
    always_comb begin
        cnt_d = cnt_q;
        if (q.step) begin
            cnt_d = q.dir ? cnt_q + 2'h1 : cnt_q - 2'h1;
        end
    end

    // Phases come straight from flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q     <= 2'h0;
            q.phase_a <= 1'b0;
            q.phase_b <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            q.phase_a <= cnt_d[1];
            q.phase_b <= cnt_d[1] ^ cnt_d[0];
        end
    end
endmodule : quad_gen
`default_nettype wire

// ---- quad_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface quad_if;
    logic step;
    logic dir;
    logic phase_a;
    logic phase_b;
    modport gen (input step, input dir, output phase_a, output phase_b);
    modport ctl (output step, output dir, input phase_a, input phase_b);
endinterface : quad_if
`default_nettype wire

// ---- test_linear_encoder_pulse_output.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_linear_encoder_pulse_output;
    typedef struct packed {logic [7:0] a; logic [31:0] v;} reg_s;
    typedef struct packed {logic [12:0] v; logic p; logic e;} res_s;
    logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, fb_step = 0, fb_dir = 0;
    logic zero_hit = 0, servo_on = 0;
    logic [31:0] haddr = 0, hwdata = 0, auto_pitch = 0, hrdata, r;
    logic [1:0]  htrans = 0, zero_id = 0;
    logic [2:0]  hsize = 3'h2;
    logic [15:0] motor_speed = 0;
    wire logic hreadyout, hresp, quad_out_a, quad_out_b, origin_out;
    wire logic brake_release_out, motor_power, alarm_out, ref_ok;
    int pos, org, p, error_cnt = 0, comparisons = 0;
    reg_s rr [10] = '{'{8'h00, 32'h0}, '{8'h04, 32'h14}, '{8'h08, 32'h7d0},
        '{8'h0c, 32'h32}, '{8'h10, 32'h0}, '{8'h14, 32'h32}, '{8'h18, 32'ha},
        '{8'h1c, 32'h0}, '{8'h28, 32'h100}, '{8'h30, 32'h0}};
    // Out of range, boundary of the upper limit, and just over it
    res_s rt [5] = '{'{13'h0, 1'b0, 1'b1}, '{13'h1, 1'b1, 1'b0}, '{13'h1c, 1'b0, 1'b0},
        '{13'h1d, 1'b0, 1'b1}, '{13'h1001, 1'b1, 1'b1}};
    enc_pulse_out #(.TICK_CYCLES(4)) u_dut (.clk, .nrst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .fb_step, .fb_dir, .zero_hit, .zero_id, .auto_pitch, .motor_speed, .servo_on,
        .quad_out_a, .quad_out_b, .origin_out, .brake_release_out, .motor_power,
        .alarm_out);
    host_model u_host (.clk, .qa(quad_out_a), .qb(quad_out_b), .qc(origin_out),
        .son(servo_on), .pos, .org, .ref_ok);
    always #12.5 clk = ~clk;
    ////////////////////////////////////////
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task results;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // Bounded wait for the slave, a hang ends the run
    task rdy;
        int n;
        n = 0;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            results();
        end
    endtask : rdy
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d = 32'h0);
        hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
        rdy();
        htrans <= 2'b00; hsel <= 0; hwdata <= d;
        rdy();
        r = hrdata;
    endtask : bus
    task st;
        bus(enc_out_pkg::OFS_STATUS, 1'b0);
    endtask : st
    task cfg(input logic [31:0] d);
        bus(enc_out_pkg::OFS_CTRL, 1'b1, d);
        repeat (2) @(posedge clk);
    endtask : cfg
    task stp(input int n, input logic d);
        repeat (n) begin
            fb_step <= 1; fb_dir <= d;
            @(posedge clk);
        end
        fb_step <= 0;
        repeat (4) @(posedge clk);
    endtask : stp
    // Cross a zero point, then move far enough for phase A to rise
    task hit(input logic [1:0] id, input logic d, input int e);
        int o;
        o = org;
        zero_hit <= 1; zero_id <= id; fb_dir <= d;
        @(posedge clk);
        zero_hit <= 0;
        stp(64, d);
        chk("origin count", 32'(org - o), 32'(e));
    endtask : hit
    task rst(input int n);
        nrst <= 0;
        repeat (n) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
    endtask : rst
    ////////////////////////////////////////
    initial begin
        rst(8);
        foreach (rr[i]) begin
            bus(rr[i].a, 1'b0);
            chk("reset value", r, rr[i].v);
        end
        p = pos; stp(256, 1'b1); chk("forward edges", 32'(pos - p), 32'h14);
        p = pos; stp(256, 1'b0); chk("reverse edges", 32'(p - pos), 32'h14);
        foreach (rt[i]) begin
            bus(enc_out_pkg::OFS_RES, 1'b1, {19'h0, rt[i].v});
            st();
            chk("error before restart", r & 32'h1, 32'(rt[i].p));
            cfg(32'h100);
            st();
            chk("setting error", r & 32'h1, 32'(rt[i].e));
        end
        chk("alarm", {31'h0, alarm_out}, 32'h1);
        bus(enc_out_pkg::OFS_RES, 1'b1, 32'h14);
        cfg(32'h100);
        hit(2'h0, 1'b0, 0);
        hit(2'h0, 1'b1, 1);
        hit(2'h0, 1'b0, 1);
        hit(2'h1, 1'b0, 0);
        cfg(32'h104);
        hit(2'h3, 1'b0, 0);
        p = pos; stp(256, 1'b1); chk("reversed sel edges", 32'(pos - p), 32'h14);
        cfg(32'h001);
        hit(2'h3, 1'b0, 0);
        cfg(32'h101);
        hit(2'h2, 1'b0, 1);
        cfg(32'h102);
        hit(2'h3, 1'b0, 1);
        rst(2);
        hit(2'h0, 1'b0, 0);
        // Short recognised pitch must win over the manual one
        auto_pitch <= 32'h3e8;
        cfg(32'h108);
        bus(enc_out_pkg::OFS_PITCH_LO, 1'b0); chk("pitch low", r, 32'h3e8);
        bus(enc_out_pkg::OFS_PITCH_HI, 1'b0); chk("pitch high", r, 32'h0);
        st(); chk("auto error", r & 32'h1, 32'h1);
        cfg(32'h100);
        servo_on <= 1; motor_speed <= 16'h48;
        repeat (20) @(posedge clk);
        chk("powered", {29'h0, ref_ok, motor_power, brake_release_out}, 32'h7);
        st(); chk("no overspeed", r & 32'h2, 32'h0);
        motor_speed <= 16'h49;
        repeat (4) @(posedge clk);
        st(); chk("overspeed", r & 32'h2, 32'h2);
        chk("power cut", {31'h0, motor_power}, 32'h0);
        motor_speed <= 16'h0;
        repeat (4) @(posedge clk);
        bus(enc_out_pkg::OFS_STATUS, 1'b1, 32'h2);
        st(); chk("overspeed clear", r & 32'h2, 32'h0);
        servo_on <= 0;
        repeat (300) @(posedge clk);
        chk("brake applied", {31'h0, brake_release_out}, 32'h0);
        results();
    end
endmodule : test_linear_encoder_pulse_output
`default_nettype wire
